// >>> rtl/vcf_defines.svh
// constants of the voice codec frame flow
`ifndef VCF_DEFINES_SVH
`define VCF_DEFINES_SVH
`define VCF_CLK_MHZ 125
`define VCF_REQ_PERIOD_MS 10
`define VCF_REQ_PERIOD_CYC (`VCF_REQ_PERIOD_MS * 1000 * `VCF_CLK_MHZ)
`define VCF_SAMPLE_RATE_HZ 8000
`define VCF_SAMPLE_CYC (`VCF_CLK_MHZ * 1000000 / `VCF_SAMPLE_RATE_HZ)
`define VCF_FRAME_BYTES 4'd10
`define VCF_FRAME_SAMPLES 7'd80
`define VCF_GROUP_FRAMES 6'd50
`define VCF_HDR_BYTE 8'h5a
`define VCF_LEVEL 20'h40000
`define VCF_PROG_WORDS 1024
`define VCF_WORD_W 20
`define VCF_ACC_W 32
`define VCF_FIFO_DEPTH 32
`endif

// >>> rtl/vcf_pkg.sv
// types of the voice codec frame flow
package vcf_pkg;
	typedef enum logic [1:0] {MODE_IDLE, MODE_DECODE, MODE_ENCODE, MODE_PROG} vcf_mode_type;
	typedef logic [7:0] vcf_byte_type;
endpackage : vcf_pkg

// >>> rtl/vcf_frame_if.sv
// parallel frame port between device and host
`timescale 1ns/100ps
interface vcf_frame_if;
	logic digitalPowerEnable;
	logic frameReq;
	logic wrStrobe;
	logic [7:0] wrData;
	logic dataAvail;
	logic rdStrobe;
	logic rdAck;
	logic [7:0] rdData;
	modport device (input digitalPowerEnable, output frameReq, input wrStrobe, input wrData,
		output dataAvail, input rdStrobe, output rdAck, output rdData);
	modport host (output digitalPowerEnable, input frameReq, output wrStrobe, output wrData,
		input dataAvail, output rdStrobe, input rdAck, input rdData);
endinterface : vcf_frame_if

// >>> rtl/vcf_device.sv
// codec device end: frame buffers, frame expansion and packing, program ram
`timescale 1ns/100ps
`include "vcf_defines.svh"
module vcf_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = `VCF_FIFO_DEPTH
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData,
	output logic [$clog2(DEPTH):0] count
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr_q;
	logic [AW-1:0] rdPtr_q;
	logic [AW:0] count_q;
	wire push = inValid && inReady;
	wire pop = outValid && outReady;
	assign inReady = count_q != DEPTH[AW:0];
	assign outValid = count_q != '0;
	assign outData = mem[rdPtr_q];
	assign count = count_q;
	always_ff @(posedge mclk) begin
		if (push) begin
			mem[wrPtr_q] <= inData;
		end
	end
	always_ff @(posedge mclk) begin
		if (rst) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else begin
			wrPtr_q <= push ? wrPtr_q + 1'b1 : wrPtr_q;
			rdPtr_q <= pop ? rdPtr_q + 1'b1 : rdPtr_q;
			count_q <= count_q + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
		end
	end
endmodule : vcf_fifo

////////////////////////////////////////////////////////////////////////////////
module vcf_device #(
	parameter int REQ_PERIOD_CYC = `VCF_REQ_PERIOD_CYC,
	parameter int SAMPLE_CYC = `VCF_SAMPLE_CYC,
	parameter int FIFO_DEPTH = `VCF_FIFO_DEPTH
) (
	input wire logic mclk,
	input wire logic rst,
	vcf_frame_if.device port,
	input wire logic startDecode,
	input wire logic startEncode,
	input wire logic encRoutineLoaded,
	input wire logic stopCodec,
	input wire logic monitorEn,
	input wire logic headerEn,
	input wire logic [7:0] volume,
	input wire logic mute,
	input wire logic progWrEn,
	input wire logic [9:0] progWrAddr,
	input wire logic [19:0] progWrData,
	input wire logic runProg,
	input wire logic [9:0] progFetchAddr,
	output logic [19:0] progFetchData,
	input wire logic sdiValid,
	input wire logic [19:0] sdiSample,
	output logic sdoValid,
	output logic [19:0] sdoSample,
	output logic encOverrun,
	output logic [1:0] modeState
);
	localparam int CW = $clog2(FIFO_DEPTH);

	function automatic logic [3:0] inc4(input logic [3:0] v);
		inc4 = (v == `VCF_FRAME_BYTES - 4'd1) ? 4'd0 : v + 4'd1;
	endfunction : inc4

	////////////////////////////////////////////////////////////////////////////
	// mode control, only while the digital part is powered
	vcf_pkg::vcf_mode_type mode_q;
	wire ctrlOk = port.digitalPowerEnable;
	always_ff @(posedge mclk) begin
		if (rst) begin
			mode_q <= vcf_pkg::MODE_IDLE;
		end else if (ctrlOk) begin
			case (mode_q)
				vcf_pkg::MODE_PROG: begin
					mode_q <= stopCodec ? vcf_pkg::MODE_IDLE : mode_q;
				end
				default: begin
					if (runProg) begin
						mode_q <= vcf_pkg::MODE_PROG;
					end else if (stopCodec) begin
						mode_q <= vcf_pkg::MODE_IDLE;
					end else if (startDecode) begin
						mode_q <= vcf_pkg::MODE_DECODE;
					end else if (startEncode && encRoutineLoaded) begin
						mode_q <= vcf_pkg::MODE_ENCODE;
					end
				end
			endcase
		end
	end
	wire decoding = mode_q == vcf_pkg::MODE_DECODE;
	wire encoding = mode_q == vcf_pkg::MODE_ENCODE;

	////////////////////////////////////////////////////////////////////////////
	// program ram: 1k words of 20 bits
	logic [`VCF_WORD_W-1:0] progRam [`VCF_PROG_WORDS];
	logic [19:0] progFetch_q;
	always_ff @(posedge mclk) begin
		if (progWrEn && ctrlOk && mode_q != vcf_pkg::MODE_PROG) begin
			progRam[progWrAddr] <= progWrData;
		end
	end
	always_ff @(posedge mclk) begin
		if (rst) begin
			progFetch_q <= '0;
		end else begin
			progFetch_q <= (mode_q == vcf_pkg::MODE_PROG) ? progRam[progFetchAddr] : '0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// decode input buffer and frame request
	logic inValid;
	logic [7:0] inHead;
	logic inPop;
	logic [CW:0] inCount;
	logic inReadyUnused;
	logic frameReq_q;
	logic reqPending_q;
	logic [3:0] wrCnt_q;
	logic [31:0] periodCnt_q;
	wire inPush = frameReq_q && port.wrStrobe;
	vcf_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) inFifo (
		.mclk(mclk), .rst(rst), .inValid(inPush), .inReady(inReadyUnused),
		.inData(port.wrData), .outValid(inValid), .outReady(inPop), .outData(inHead),
		.count(inCount));
	wire periodHit = periodCnt_q == 32'(REQ_PERIOD_CYC - 1);
	wire roomForFrame = (CW+1)'(FIFO_DEPTH) - inCount >= (CW+1)'(`VCF_FRAME_BYTES);
	always_ff @(posedge mclk) begin
		if (rst || !decoding) begin
			periodCnt_q <= '0;
			reqPending_q <= 1'b0;
			frameReq_q <= 1'b0;
			wrCnt_q <= '0;
		end else begin
			periodCnt_q <= periodHit ? '0 : periodCnt_q + 32'd1;
			if (!frameReq_q && (reqPending_q || periodHit) && roomForFrame) begin
				frameReq_q <= 1'b1;
				reqPending_q <= 1'b0;
			end else begin
				reqPending_q <= reqPending_q || periodHit;
				if (inPush) begin
					wrCnt_q <= inc4(wrCnt_q);
					frameReq_q <= wrCnt_q != `VCF_FRAME_BYTES - 4'd1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// expansion: byte pairs swapped, one bit per sample, then volume
	logic [7:0] pairByte_q;
	logic pairHave_q;
	logic [15:0] word_q;
	logic [4:0] bitsLeft_q;
	logic [31:0] tickCnt_q;
	wire tick = tickCnt_q == 32'(SAMPLE_CYC - 1);
	assign inPop = decoding && inValid && bitsLeft_q == 5'd0;
	wire signed [19:0] rawSample = word_q[15] ? `VCF_LEVEL : -`VCF_LEVEL;
	wire signed [`VCF_ACC_W-1:0] acc = `VCF_ACC_W'(rawSample) * $signed({1'b0, volume});
	wire [19:0] decSample = mute ? 20'h00000 : acc[26:7];
	always_ff @(posedge mclk) begin
		if (rst || !decoding) begin
			pairHave_q <= 1'b0;
			pairByte_q <= '0;
			word_q <= '0;
			bitsLeft_q <= '0;
		end else if (inPop) begin
			pairHave_q <= !pairHave_q;
			pairByte_q <= inHead;
			if (pairHave_q) begin
				word_q <= {inHead, pairByte_q};
				bitsLeft_q <= 5'd16;
			end
		end else if (tick && bitsLeft_q != 5'd0) begin
			word_q <= {word_q[14:0], 1'b0};
			bitsLeft_q <= bitsLeft_q - 5'd1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// serial audio output: decoded samples or monitored input
	logic sdoValid_q;
	logic [19:0] sdoSample_q;
	always_ff @(posedge mclk) begin
		if (rst) begin
			tickCnt_q <= '0;
			sdoValid_q <= 1'b0;
			sdoSample_q <= '0;
		end else begin
			tickCnt_q <= tick ? '0 : tickCnt_q + 32'd1;
			sdoValid_q <= (decoding && tick && bitsLeft_q != 5'd0) ||
				(encoding && monitorEn && sdiValid);
			if (decoding && tick && bitsLeft_q != 5'd0) begin
				sdoSample_q <= decSample;
			end else if (encoding && monitorEn && sdiValid) begin
				sdoSample_q <= sdiSample;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// encoder: sign bit per sample, 16 samples to a swapped byte pair
	logic [15:0] encShift_q;
	logic [3:0] encBits_q;
	logic [15:0] encWord_q;
	logic [1:0] encPend_q;
	logic [6:0] sampleCnt_q;
	logic [5:0] groupCnt_q;
	logic [3:0] hdrLeft_q;
	logic overrun_q;
	logic outReady;
	wire outPushWant = hdrLeft_q != 4'd0 || encPend_q != 2'd0;
	wire outPush = encoding && outPushWant && outReady;
	wire [7:0] outByte = hdrLeft_q != 4'd0 ? `VCF_HDR_BYTE :
		(encPend_q == 2'd2 ? encWord_q[7:0] : encWord_q[15:8]);
	wire takeSample = encoding && sdiValid;
	wire pairDone = takeSample && encBits_q == 4'd15;
	always_ff @(posedge mclk) begin
		if (rst || !encoding) begin
			encShift_q <= '0;
			encBits_q <= '0;
			encWord_q <= '0;
			encPend_q <= '0;
			sampleCnt_q <= '0;
			groupCnt_q <= '0;
			hdrLeft_q <= '0;
			overrun_q <= rst ? 1'b0 : overrun_q;
		end else begin
			if (takeSample) begin
				encShift_q <= {encShift_q[14:0], sdiSample[19]};
				encBits_q <= encBits_q + 4'd1;
				sampleCnt_q <= sampleCnt_q == `VCF_FRAME_SAMPLES - 7'd1 ? '0 : sampleCnt_q + 7'd1;
				if (sampleCnt_q == `VCF_FRAME_SAMPLES - 7'd1) begin
					groupCnt_q <= groupCnt_q == `VCF_GROUP_FRAMES - 6'd1 ? '0 : groupCnt_q + 6'd1;
				end
				if (sampleCnt_q == 7'd0 && groupCnt_q == 6'd0 && headerEn) begin
					hdrLeft_q <= `VCF_FRAME_BYTES;
				end else if (outPush && hdrLeft_q != 4'd0) begin
					hdrLeft_q <= hdrLeft_q - 4'd1;
				end
			end else if (outPush && hdrLeft_q != 4'd0) begin
				hdrLeft_q <= hdrLeft_q - 4'd1;
			end
			if (pairDone) begin
				encWord_q <= {encShift_q[14:0], sdiSample[19]};
				encPend_q <= 2'd2;
				overrun_q <= overrun_q || encPend_q != 2'd0;
			end else if (outPush && hdrLeft_q == 4'd0) begin
				encPend_q <= encPend_q - 2'd1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// output buffer, frame accounting and read port
	logic outValid;
	logic [7:0] outHead;
	logic [3:0] pushCnt_q;
	logic [3:0] readCnt_q;
	logic [CW:0] framesReady_q;
	logic [CW:0] framesReady_d;
	logic dataAvail_q;
	logic rdAck_q;
	logic [7:0] rdData_q;
	wire outPop = port.rdStrobe && outValid;
	wire frameIn = outPush && pushCnt_q == `VCF_FRAME_BYTES - 4'd1;
	wire frameOut = outPop && readCnt_q == `VCF_FRAME_BYTES - 4'd1;
	vcf_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) outFifo (
		.mclk(mclk), .rst(rst), .inValid(outPush), .inReady(outReady), .inData(outByte),
		.outValid(outValid), .outReady(outPop), .outData(outHead), .count());
	always_comb begin
		framesReady_d = framesReady_q + (frameIn ? 1'b1 : 1'b0) - (frameOut ? 1'b1 : 1'b0);
	end
	always_ff @(posedge mclk) begin
		if (rst) begin
			pushCnt_q <= '0;
			readCnt_q <= '0;
			framesReady_q <= '0;
			dataAvail_q <= 1'b0;
			rdAck_q <= 1'b0;
			rdData_q <= '0;
		end else begin
			pushCnt_q <= outPush ? inc4(pushCnt_q) : pushCnt_q;
			readCnt_q <= outPop ? inc4(readCnt_q) : readCnt_q;
			framesReady_q <= framesReady_d;
			dataAvail_q <= framesReady_d != '0;
			rdAck_q <= outPop;
			rdData_q <= outPop ? outHead : rdData_q;
		end
	end

	assign port.frameReq = frameReq_q;
	assign port.dataAvail = dataAvail_q;
	assign port.rdAck = rdAck_q;
	assign port.rdData = rdData_q;
	assign progFetchData = progFetch_q;
	assign sdoValid = sdoValid_q;
	assign sdoSample = sdoSample_q;
	assign encOverrun = overrun_q;
	assign modeState = mode_q;
endmodule : vcf_device

// >>> rtl/vcf_host.sv
// host end: feeds frames on request, collects encoded bytes
`timescale 1ns/100ps
`include "vcf_defines.svh"
module vcf_host (
	input wire logic mclk,
	input wire logic rst,
	vcf_frame_if.host port,
	input wire logic powerOn,
	input wire logic txValid,
	input wire logic [7:0] txData,
	output logic txTaken,
	output logic rxValid,
	output logic [7:0] rxData
);
	logic power_q;
	logic wrStrobe_q;
	logic [7:0] wrData_q;
	logic [3:0] wrCnt_q;
	logic rdStrobe_q;
	logic rdBusy_q;
	logic rxValid_q;
	logic [7:0] rxData_q;
	wire canWrite = power_q && port.frameReq && wrCnt_q != `VCF_FRAME_BYTES && !wrStrobe_q;
	wire takeTx = canWrite && txValid;
	wire startRd = power_q && port.dataAvail && !rdBusy_q && !rdStrobe_q;

	always_ff @(posedge mclk) begin
		if (rst) begin
			power_q <= 1'b0;
			wrStrobe_q <= 1'b0;
			wrData_q <= '0;
			wrCnt_q <= '0;
		end else begin
			power_q <= powerOn;
			wrStrobe_q <= takeTx;
			wrData_q <= takeTx ? txData : wrData_q;
			if (takeTx) begin
				wrCnt_q <= wrCnt_q + 4'd1;
			end else if (!port.frameReq && !wrStrobe_q) begin
				wrCnt_q <= '0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// reads: one strobe outstanding until its acknowledge
	always_ff @(posedge mclk) begin
		if (rst) begin
			rdStrobe_q <= 1'b0;
			rdBusy_q <= 1'b0;
			rxValid_q <= 1'b0;
			rxData_q <= '0;
		end else begin
			rdStrobe_q <= startRd;
			rdBusy_q <= startRd || (rdBusy_q && !port.rdAck);
			rxValid_q <= port.rdAck;
			rxData_q <= port.rdAck ? port.rdData : rxData_q;
		end
	end

	assign port.digitalPowerEnable = power_q;
	assign port.wrStrobe = wrStrobe_q;
	assign port.wrData = wrData_q;
	assign port.rdStrobe = rdStrobe_q;
	assign txTaken = wrStrobe_q;
	assign rxValid = rxValid_q;
	assign rxData = rxData_q;
endmodule : vcf_host

// >>> tb/vcf_frame_properties.sv
// interface checks of the voice codec frame flow
`timescale 1ns/100ps
module vcf_frame_properties (
	input wire logic mclk,
	input wire logic rst,
	input wire logic digitalPowerEnable,
	input wire logic frameReq,
	input wire logic wrStrobe,
	input wire logic dataAvail,
	input wire logic rdStrobe,
	input wire logic rdAck,
	input wire logic [7:0] rdData
);
	logic [3:0] wrCnt_q;
	logic [3:0] rdCnt_q;
	always_ff @(posedge mclk) begin
		if (rst || !frameReq) wrCnt_q <= 4'h0;
		else if (wrStrobe) wrCnt_q <= wrCnt_q + 4'h1;
	end
	always_ff @(posedge mclk) begin
		if (rst) rdCnt_q <= 4'h0;
		else if (rdAck) rdCnt_q <= (rdCnt_q == 4'h9) ? 4'h0 : rdCnt_q + 4'h1;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	a_req_ten_bytes: assert property ($fell(frameReq) |-> wrCnt_q == 4'ha || wrCnt_q == 4'h0)
		else $error("frame request ended on a partial byte count");
	a_req_drops: assert property (wrStrobe && frameReq && wrCnt_q == 4'h9 |=> !frameReq)
		else $error("frame request held after ten bytes");
	a_wr_on_req: assert property (wrStrobe |-> frameReq)
		else $error("byte written without a request");
	a_wr_spaced: assert property (wrStrobe |=> !wrStrobe)
		else $error("host wrote bytes back to back");
	a_ack_after_strobe: assert property (rdAck |-> $past(rdStrobe))
		else $error("read ack without a read strobe");
	a_rddata_holds: assert property (!rdAck |-> $stable(rdData))
		else $error("read data moved without an ack");
	a_req_powered: assert property ($rose(frameReq) |-> $past(digitalPowerEnable))
		else $error("frame request raised while unpowered");
	a_avail_whole_unit: assert property (
		$fell(dataAvail) |-> rdCnt_q == 4'h0 || (rdAck && rdCnt_q == 4'h9))
		else $error("data available fell inside a unit");
endmodule : vcf_frame_properties

// >>> tb/test_voice_codec_frame_flow.sv
// self-checking bench of the voice codec frame flow
`timescale 1ns/100ps
module test_voice_codec_frame_flow;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic startDecode = 1'b0, startEncode = 1'b0, encRoutineLoaded = 1'b0, stopCodec = 1'b0;
	logic monitorEn = 1'b1, headerEn = 1'b1, mute = 1'b0, progWrEn = 1'b0, runProg = 1'b0;
	logic sdiValid = 1'b0, powerOn = 1'b0, txValid = 1'b0;
	logic [7:0] volume = 8'h80, txData = 8'h00;
	logic [9:0] progWrAddr = 10'h000, progFetchAddr = 10'h000;
	logic [19:0] progWrData = 20'h00000, sdiSample = 20'h00000;
	logic [19:0] progFetchData, sdoSample;
	logic sdoValid, encOverrun, txTaken, rxValid;
	logic [1:0] modeState;
	logic [7:0] rxData;
	int n_errors = 0, tests_run = 0, seed = 76190, nTaken = 0;
	logic [19:0] sdoQ[$];
	logic [7:0] rxQ[$];
	vcf_frame_if vcf_frame_if_i ();
	vcf_device #(.REQ_PERIOD_CYC(200), .SAMPLE_CYC(4), .FIFO_DEPTH(32)) vcf_device_i (.mclk, .rst,
		.port(vcf_frame_if_i), .startDecode, .startEncode, .encRoutineLoaded, .stopCodec,
		.monitorEn, .headerEn, .volume, .mute, .progWrEn, .progWrAddr, .progWrData, .runProg,
		.progFetchAddr, .progFetchData, .sdiValid, .sdiSample, .sdoValid, .sdoSample,
		.encOverrun, .modeState);
	vcf_host vcf_host_i (.mclk, .rst, .port(vcf_frame_if_i), .powerOn, .txValid, .txData,
		.txTaken, .rxValid, .rxData);
	vcf_frame_properties vcf_frame_properties_i (.mclk, .rst,
		.digitalPowerEnable(vcf_frame_if_i.digitalPowerEnable),
		.frameReq(vcf_frame_if_i.frameReq), .wrStrobe(vcf_frame_if_i.wrStrobe),
		.dataAvail(vcf_frame_if_i.dataAvail), .rdStrobe(vcf_frame_if_i.rdStrobe),
		.rdAck(vcf_frame_if_i.rdAck), .rdData(vcf_frame_if_i.rdData));
	always #4 mclk = ~mclk;
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [19:0] seen, input logic [19:0] exp, input string what);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic complete_run;
		if (n_errors == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : complete_run
	task automatic pulse(ref logic sig);
		sig = 1'b1;
		@(negedge mclk);
		sig = 1'b0;
		repeat (2) @(negedge mclk);
	endtask : pulse
	task automatic settle();
		for (int k = 0; k < 4000 && (sdoQ.size() || rxQ.size()); k++) @(negedge mclk);
	endtask : settle
	////////////////////////////////////////////////////////////////////////////////
	// results are taken off the queues as the outputs show them
	always @(posedge mclk) begin
		#1;
		if (sdoValid) check(sdoSample, sdoQ.size() ? sdoQ.pop_front() : 20'hxxxxx, "sample");
		if (rxValid) check({12'h000, rxData}, rxQ.size() ? {12'h000, rxQ.pop_front()} : 20'hxxxxx, "byte");
	end
	initial begin
		#400000;
		n_errors++;
		complete_run();
	end
	initial begin
		logic [7:0] fr[10];
		logic [15:0] sg;
		logic [15:0] w;
		logic [19:0] lvl;
		int r;
		int k;
		repeat (3) @(negedge mclk);
		rst = 1'b0;
		check({18'h0, modeState}, 20'h0, "reset mode");
		pulse(startDecode);
		check({18'h0, modeState}, 20'h0, "unpowered decode");
		powerOn = 1'b1;
		repeat (2) @(negedge mclk);
		pulse(startEncode);
		check({18'h0, modeState}, 20'h0, "refused encode");
		r = $random(seed);
		progWrData = r[19:0];
		progWrAddr = 10'h3ff;
		pulse(progWrEn);
		pulse(runProg);
		pulse(startDecode);
		progFetchAddr = 10'h3ff;
		repeat (2) @(negedge mclk);
		check(progFetchData, progWrData, "program word");
		check({18'h0, modeState}, 20'h3, "program mode");
		pulse(stopCodec);
		r = $random(seed);
		volume = r[7:0] | 8'h01;
		lvl = 20'((32'h40000 * volume) >> 7);
		pulse(startDecode);
		// the last frame is played muted, after the earlier ones have drained
		for (int f = 0; f < 4; f++) begin
			if (f == 3) begin
				txValid = 1'b0;
				settle();
				mute = 1'b1;
				@(negedge mclk);
			end
			for (int i = 0; i < 10; i++) begin
				r = $random(seed);
				fr[i] = r[7:0];
			end
			for (int p = 0; p < 10; p += 2) begin
				w = {fr[p + 1], fr[p]};
				for (int b = 15; b >= 0; b--) begin
					sdoQ.push_back(mute ? 20'h00000 : (w[b] ? lvl : -lvl));
				end
			end
			for (int i = 0; i < 10; i++) begin
				txData = fr[i];
				txValid = 1'b1;
				for (k = 0; k < 1000; k++) begin
					@(negedge mclk);
					if (txTaken) begin
						nTaken++;
						break;
					end
				end
			end
		end
		txValid = 1'b0;
		settle();
		pulse(stopCodec);
		encRoutineLoaded = 1'b1;
		pulse(startEncode);
		check({18'h0, modeState}, 20'h2, "encode mode");
		for (int i = 0; i < 10; i++) rxQ.push_back(8'h5a);
		for (int s = 0; s < 160; s++) begin
			r = $random(seed);
			sdiSample = r[19:0];
			sdoQ.push_back(sdiSample);
			sg = {sg[14:0], sdiSample[19]};
			if (s % 16 == 15) begin
				rxQ.push_back(sg[7:0]);
				rxQ.push_back(sg[15:8]);
			end
			pulse(sdiValid);
			@(negedge mclk);
		end
		settle();
		check({19'h0, encOverrun}, 20'h0, "overrun");
		check(nTaken[19:0], 20'd40, "bytes taken");
		check(20'(sdoQ.size()), 20'h0, "samples left");
		check(20'(rxQ.size()), 20'h0, "bytes left");
		complete_run();
	end
endmodule : test_voice_codec_frame_flow
